//--- hw/i2cs_pkg.sv
// Shared constants and types of the I2C slave address and stretch block.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package i2cs_pkg;
   // APB byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_RXB  = 8'h0C;
   localparam logic [7:0] OFS_TXB  = 8'h10;
   // Control register bit positions
   localparam int CB_EN    = 15;
   localparam int CB_REL   = 12;
   localparam int CB_A10   = 10;
   localparam int CB_STRETCH_ENABLE = 6;
   // Status register bit positions
   localparam int SB_TBF  = 0;
   localparam int SB_RBF  = 1;
   localparam int SB_RW   = 2;
   localparam int SB_EVT  = 3;
   localparam int SB_OV   = 6;
   localparam int SB_TENM = 8;
   // Reset values and fixed patterns
   localparam logic [9:0] ADDR_RST = 10'h000;
   localparam logic [4:0] TEN_HDR  = 5'h1E;
   localparam logic [3:0] BITS_BYTE = 4'h8;

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_RECV = 5'h02,
      S_ACK  = 5'h04,
      S_SEND = 5'h08,
      S_MACK = 5'h10
   } i2cs_st_t;

   typedef enum logic [1:0] {
      K_ADR1 = 2'h0,
      K_ADR2 = 2'h1,
      K_DATA = 2'h2
   } i2cs_kind_t;

   // Filtered line with its edge pulses
   typedef struct packed {
      logic lvl;
      logic rise;
      logic fall;
   } i2cs_line_t;

   // Bus conditions
   typedef struct packed {
      logic start;
      logic stop;
   } i2cs_cond_t;
endpackage

//--- hw/i2cs_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous pin; idle level of the line is high.
`timescale 1ns/100ps
module i2cs_sync (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              pin,
   output i2cs_pkg::i2cs_line_t   line
);
   import i2cs_pkg::*;

   typedef struct packed {
      logic [2:0] s;
      logic       lvl;
      logic       rise;
      logic       fall;
   } i2cs_sync_t;

   i2cs_sync_t q;
   i2cs_sync_t d;

   // Level moves only when stages two and three agree
   always_comb begin
      d = q;
      d.s = {q.s[1:0], pin};
      d.rise = 1'b0;
      d.fall = 1'b0;
      if (q.s[1] == q.s[2] && q.s[2] != q.lvl) begin
         d.lvl = q.s[2];
         d.rise = q.s[2];
         d.fall = ~q.s[2];
      end
   end

   // Constants only under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{s: 3'h7, lvl: 1'b1, rise: 1'b0, fall: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign line = '{lvl: q.lvl, rise: q.rise, fall: q.fall};
endmodule

//--- hw/i2cs_cond.sv
// Start and stop condition detector on filtered SCL and SDA.
// Assumes both lines come through equal synchroniser delays.
`timescale 1ns/100ps
module i2cs_cond (
   input  i2cs_pkg::i2cs_line_t scl,
   input  i2cs_pkg::i2cs_line_t sda,
   output i2cs_pkg::i2cs_cond_t cond
);
   import i2cs_pkg::*;

   // SDA moving while SCL is high marks a condition
   assign cond.start = sda.fall & scl.lvl;
   assign cond.stop  = sda.rise & scl.lvl;
endmodule

//--- hw/i2cs_top.sv
// I2C slave: address match, transmit, receive, clock stretching, APB.
// Assumes open-drain pads resolved outside; APB master on pclk.
`timescale 1ns/100ps
// Overview of operation
// - Ten-bit select clear in control bit 10 means 7-bit addressing
// - 7-bit: address bits 6:0 against shift bits 7:1, bit 0 is R/W
// - When enabled, idle until Start, then shift 8 address bits
// - Every incoming bit is sampled on SCL rising edge
// - Address match: ACK, event at ninth fall, receive buffer untouched
// - Read address: transmit, hold SCL low until data and release
// - Transmit data changes on SCL falling edges
// - Transmit: event pulse at ninth fall whatever the master ACK
// - Receive: after 8 bits load buffer if not full, ACK ninth if overflow clear
// - Buffer full at byte end: NACK, no load, event still pulses
// - Overflow set, buffer empty: load buffer yet answer NACK
// - 10-bit first byte: bits 7:3 = 11110, 2:1 = address 9:8
// - First byte match write: event, clear ten flag; match read with ten flag: transmit; else idle
// - Second byte against address 7:0; match sets ten flag
// - After full 10-bit match, restart with read enters transmit
// - Transmit ACK with transmit buffer empty clears release, holds SCL
// - Transmit buffer loaded before ninth fall: no stretch
// - Software may set release at any time
// - Stretch enabled, receive full at ninth fall: clear release
// - Buffer read before ninth fall: no release clear, no stretch
// - Software release clear holds SCL only after a sampled fall
// - Stretch disabled: software clears of release are ignored, sets still apply
// - After a read restart in 10-bit mode only first byte must match
module i2cs_top #(
   parameter int DATA_W = 32
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             slave_event_flag
);
   import i2cs_pkg::*;

   if (DATA_W != 32) begin : g_bad_width
      $error("i2cs_top serves only 32-bit APB data");
   end

   typedef struct packed {
      i2cs_st_t   st;
      i2cs_kind_t kind;
      i2cs_kind_t nk;
      logic [3:0] cnt;
      logic [7:0] sr;
      logic [7:0] tsr;
      logic       ackd;
      logic       tx;
      logic       loaded;
      logic       rw;
      logic       en;
      logic       a10;
      logic       stretch_enable;
      logic       rel;
      logic       hold;
      logic [9:0] addr;
      logic [7:0] rxb;
      logic [7:0] txb;
      logic       receive_full_flag;
      logic       transmit_full_flag;
      logic       ov;
      logic       tenm;
      logic       evt;
      logic       evts;
   } i2cs_state_t;

   i2cs_state_t q;
   i2cs_state_t n;
   i2cs_line_t  scl;
   i2cs_line_t  sda;
   i2cs_cond_t  cond;
   logic        wr;
   logic        rd;
   logic        dec;

   // 7-bit address compare
   function automatic logic m7(input logic [7:0] s, input logic [9:0] a);
      return s[7:1] == a[6:0];
   endfunction

   // 10-bit header compare
   function automatic logic m10(input logic [7:0] s, input logic [9:0] a);
      return s[7:3] == TEN_HDR && s[2:1] == a[9:8];
   endfunction

   i2cs_sync u_scl (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (scl_i),
      .line    (scl)
   );

   i2cs_sync u_sda (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (sda_i),
      .line    (sda)
   );

   i2cs_cond u_cond (
      .scl  (scl),
      .sda  (sda),
      .cond (cond)
   );

   // APB strobes; zero wait states
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign dec = q.st == S_RECV && scl.fall && q.cnt == BITS_BYTE;

   // Next state: software first, so hardware updates win over software writes
   always_comb begin
      n = q;
      n.evt = 1'b0;
      if (wr) begin
         case (paddr)
            OFS_CTRL: begin
               n.en = pwdata[CB_EN];
               n.a10 = pwdata[CB_A10];
               n.stretch_enable = pwdata[CB_STRETCH_ENABLE];
               if (pwdata[CB_REL]) begin
                  n.rel = 1'b1;
               end else if (q.stretch_enable) begin
                  n.rel = 1'b0;
               end
            end
            OFS_STAT: begin
               n.ov = q.ov & pwdata[SB_OV];
               if (pwdata[SB_EVT]) begin
                  n.evts = 1'b0;
               end
            end
            OFS_ADDR: n.addr = pwdata[9:0];
            OFS_TXB: begin
               n.txb = pwdata[7:0];
               n.transmit_full_flag = 1'b1;
            end
            default: ;
         endcase
      end
      if (rd && paddr == OFS_RXB) begin
         n.receive_full_flag = 1'b0;
      end
      if (!q.en) begin
         n.st = S_IDLE;
      end else if (cond.stop) begin
         n.st = S_IDLE;
      end else if (cond.start) begin
         n.st = S_RECV;
         n.kind = K_ADR1;
         n.cnt = 4'h0;
      end else begin
         case (q.st)
            S_IDLE: ;
            S_RECV: begin
               if (scl.rise && q.cnt != BITS_BYTE) begin
                  n.sr = {q.sr[6:0], sda.lvl};
                  n.cnt = q.cnt + 4'h1;
               end else if (dec) begin
                  n.st = S_IDLE;
                  n.ackd = 1'b0;
                  n.tx = 1'b0;
                  n.nk = K_DATA;
                  case (q.kind)
                     K_ADR1: begin
                        n.rw = q.sr[0];
                        if (!q.a10) begin
                           if (m7(q.sr, q.addr)) begin
                              n.st = S_ACK;
                              n.ackd = 1'b1;
                              n.tx = q.sr[0];
                           end
                        end else if (m10(q.sr, q.addr) && !q.sr[0]) begin
                           n.st = S_ACK;
                           n.ackd = 1'b1;
                           n.tenm = 1'b0;
                           n.nk = K_ADR2;
                        end else if (m10(q.sr, q.addr) && q.tenm) begin
                           n.st = S_ACK;
                           n.ackd = 1'b1;
                           n.tx = 1'b1;
                        end else begin
                           n.tenm = 1'b0;
                        end
                     end
                     K_ADR2: begin
                        if (q.sr == q.addr[7:0]) begin
                           n.st = S_ACK;
                           n.ackd = 1'b1;
                           n.tenm = 1'b1;
                        end else begin
                           n.tenm = 1'b0;
                        end
                     end
                     default: begin
                        n.st = S_ACK;
                        if (q.receive_full_flag) begin
                           n.ov = 1'b1;
                        end else begin
                           n.rxb = q.sr;
                           n.receive_full_flag = 1'b1;
                           n.ackd = ~q.ov;
                        end
                     end
                  endcase
               end
            end
            S_ACK: begin
               if (scl.fall) begin
                  n.evt = 1'b1;
                  n.cnt = 4'h0;
                  n.kind = q.nk;
                  if (q.tx) begin
                     n.st = S_SEND;
                     n.loaded = 1'b0;
                     if (!q.transmit_full_flag) begin
                        n.rel = 1'b0;
                     end
                  end else begin
                     n.st = S_RECV;
                     if (q.kind == K_DATA && q.stretch_enable && q.receive_full_flag) begin
                        n.rel = 1'b0;
                     end
                  end
               end
            end
            S_SEND: begin
               if (!q.loaded) begin
                  if (q.transmit_full_flag && q.rel) begin
                     n.tsr = q.txb;
                     // A write in the load cycle stays pending
                     n.transmit_full_flag = wr && paddr == OFS_TXB;
                     n.loaded = 1'b1;
                  end
               end else if (scl.rise) begin
                  n.cnt = q.cnt + 4'h1;
               end else if (scl.fall) begin
                  if (q.cnt == BITS_BYTE) begin
                     n.st = S_MACK;
                  end else begin
                     n.tsr = {q.tsr[6:0], 1'b0};
                  end
               end
            end
            S_MACK: begin
               if (scl.rise) begin
                  n.ackd = ~sda.lvl;
               end else if (scl.fall) begin
                  n.evt = 1'b1;
                  if (q.ackd) begin
                     n.st = S_SEND;
                     n.cnt = 4'h0;
                     n.loaded = 1'b0;
                     if (!q.transmit_full_flag) begin
                        n.rel = 1'b0;
                     end
                  end else begin
                     n.st = S_IDLE;
                  end
               end
            end
            default: n.st = S_IDLE;
         endcase
      end
      // Hold waits for a seen fall, so high time is never cut short
      n.hold = ~n.rel & (q.hold | scl.fall);
      if (n.evt) begin
         n.evts = 1'b1;
      end
   end

   // Single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{st: S_IDLE, kind: K_ADR1, nk: K_ADR1, cnt: 4'h0,
                sr: 8'h00, tsr: 8'h00, rel: 1'b1, addr: ADDR_RST,
                rxb: 8'h00, txb: 8'h00, default: 1'b0};
      end else begin
         q <= n;
      end
   end

   // Pins only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = q.hold;
   assign sda_oe = (q.st == S_ACK && q.ackd) ||
                   (q.st == S_SEND && q.loaded && !q.tsr[7]);
   assign slave_event_flag = q.evt;

   // Read mux and unmapped answer
   assign pready = 1'b1;
   assign pslverr = psel & penable &
                    !(paddr inside {OFS_CTRL, OFS_STAT, OFS_ADDR,
                                    OFS_RXB, OFS_TXB});
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: begin
            prdata[CB_EN] = q.en;
            prdata[CB_REL] = q.rel;
            prdata[CB_A10] = q.a10;
            prdata[CB_STRETCH_ENABLE] = q.stretch_enable;
         end
         OFS_STAT: begin
            prdata[SB_TBF] = q.transmit_full_flag;
            prdata[SB_RBF] = q.receive_full_flag;
            prdata[SB_RW] = q.rw;
            prdata[SB_EVT] = q.evts;
            prdata[SB_OV] = q.ov;
            prdata[SB_TENM] = q.tenm;
         end
         OFS_ADDR: prdata[9:0] = q.addr;
         OFS_RXB: prdata[7:0] = q.rxb;
         OFS_TXB: prdata[7:0] = q.txb;
         default: ;
      endcase
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   addr7_ack_a: assert property (
      dec && q.kind == K_ADR1 && !q.a10 && m7(q.sr, q.addr) && !cond.start
      && !cond.stop |=> q.st == S_ACK && q.ackd ##0 sda_oe)
      else $error("7-bit match not acknowledged");
   rx_sample_a: assert property (
      q.st == S_RECV && scl.rise && q.cnt < BITS_BYTE && q.en && !cond.start
      && !cond.stop |=> q.sr[0] == $past(sda.lvl))
      else $error("bit not sampled on SCL rise");
   ack_evt_a: assert property (
      q.st == S_ACK && scl.fall && q.en && !cond.start && !cond.stop
      |=> slave_event_flag ##1 !slave_event_flag)
      else $error("no event at ninth fall");
   full_nack_a: assert property (
      dec && q.kind == K_DATA && q.receive_full_flag && q.en && !cond.start && !cond.stop
      |=> !q.ackd && q.rxb == $past(q.rxb) && q.ov)
      else $error("full buffer answered wrongly");
   ov_load_a: assert property (
      dec && q.kind == K_DATA && !q.receive_full_flag && q.ov && q.en && !cond.start
      && !cond.stop |=> !q.ackd && q.rxb == $past(q.sr) && q.receive_full_flag)
      else $error("overflow load or nack wrong");
   ten_hdr_a: assert property (
      dec && q.kind == K_ADR1 && q.a10 && !m10(q.sr, q.addr) && q.en
      && !cond.start && !cond.stop |=> q.st == S_IDLE && !q.tenm)
      else $error("10-bit mismatch not idle");
   tx_stretch_a: assert property (
      q.st == S_MACK && scl.fall && q.ackd && !q.transmit_full_flag && q.en && !cond.start
      && !cond.stop && !wr |=> !q.rel && scl_oe)
      else $error("transmit stretch missing");
   rel_ignore_a: assert property (
      wr && paddr == OFS_CTRL && !q.stretch_enable && !pwdata[CB_REL]
      && !(q.st inside {S_ACK, S_MACK}) |=> q.rel == $past(q.rel))
      else $error("release changed with stretch off");
   hold_cause_a: assert property (
      $rose(scl_oe) |-> !q.rel && $past(scl.fall))
      else $error("SCL held without a seen fall");

   tx_cov: cover property (q.st == S_MACK ##1 q.st == S_SEND);
   rx_cov: cover property (dec && q.kind == K_DATA && !q.receive_full_flag);
   ten_cov: cover property ($rose(q.tenm));
   str_cov: cover property ($rose(scl_oe));
endmodule

//--- bench/i2cs_bfm.sv
// Behavioural I2C bus master pulling SCL and SDA as open-drain lines.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/100ps
module i2cs_bfm #(
   parameter int LOW_NS  = 60,
   parameter int HIGH_NS = 18
) (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low,
   output logic      sda_low,
   output logic      stuck
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      stuck   = 1'b0;
   end

   // Let SCL rise; a slave may stretch, so wait on the wire, bounded
   task automatic clk_high();
      int n;
      scl_low = 1'b0;
      n = 0;
      while (scl !== 1'b1 && n < 50000) begin
         #1;
         n++;
      end
      if (n >= 50000)
         stuck = 1'b1;
      #(HIGH_NS);
   endtask

   // Data set early in the low phase, sampled late in the high phase
   task automatic bit_io(input logic b, output logic s);
      #10;
      sda_low = ~b;
      #(LOW_NS - 10);
      clk_high();
      s = sda;
      scl_low = 1'b1;
   endtask

   // Start or repeated start: SDA falls while SCL is high
   task automatic start();
      #10;
      sda_low = 1'b0;
      #(LOW_NS - 10);
      clk_high();
      sda_low = 1'b1;
      #(HIGH_NS);
      scl_low = 1'b1;
   endtask

   // Stop: SDA rises while SCL is high
   task automatic stop();
      #10;
      sda_low = 1'b1;
      #(LOW_NS - 10);
      clk_high();
      sda_low = 1'b0;
      #(LOW_NS);
   endtask

   // Byte out MSB first, then the acknowledge slot
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   // Byte in MSB first; ack_me low answers not-acknowledge
   task automatic get_byte(input logic ack_me, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(~ack_me, s);
   endtask
endmodule

//--- bench/tb_i2c_slave_addr_clock_stretch.sv
// Self-checking bench of the I2C slave: APB master, bus model, checks.
// Assumes the design files and the bus model are compiled first.
`timescale 1ns/100ps
module tb_i2c_slave_addr_clock_stretch;
   import i2cs_pkg::*;
   localparam logic [31:0] M_REL = 32'h1 << CB_REL;
   localparam logic [31:0] M_RBF = 32'h1 << SB_RBF;
   localparam logic [31:0] M_OV  = 32'h1 << SB_OV;
   localparam logic [31:0] M_TEN = 32'h1 << SB_TENM;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, d0, d1, d2, got;
   logic [31:0] pwdata, prdata, rd;
   logic        scl_oe, sda_oe, evt, m_scl, m_sda, m_stuck, er, ack;
   logic [9:0]  adr;
   wire         scl_w, sda_w;
   wire         m_scl_dl, m_sda_dl;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          n_evt      = 0;

   // Master pins move just off the clock edge, so sampling never races
   assign #2 m_scl_dl = m_scl;
   assign #2 m_sda_dl = m_sda;
   // Open-drain wires with pull-ups
   assign scl_w = ~(scl_oe | m_scl_dl);
   assign sda_w = ~(sda_oe | m_sda_dl);

   i2cs_top i2cs_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
      .slave_event_flag(evt)
   );
   i2cs_bfm i2cs_bfm_inst (
      .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda),
      .stuck(m_stuck)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // One count per event pulse
   always @(posedge pclk) begin
      if (evt === 1'b1)
         n_evt++;
   end

   function automatic logic [31:0] ctl(input logic st, a10, rel);
      return (32'h1 << CB_EN) | ({31'h0, rel} << CB_REL) |
             ({31'h0, a10} << CB_A10) | ({31'h0, st} << CB_STRETCH_ENABLE);
   endfunction
   function automatic logic [7:0] hdr10(input logic [9:0] a, input logic w);
      return {TEN_HDR, a[9:8], w};
   endfunction
   // Receiver acknowledges only with empty buffer and no overflow
   function automatic logic rx_ack(input logic full, input logic ov);
      return ~full & ~ov;
   endfunction

   task automatic close_out();
      if (m_stuck === 1'b1)
         n_mismatch++;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Setup then access; held until pready seen high, bounded
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r,
                      output logic e);
      int n;
      logic rdy;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      rdy = 1'b0;
      // Answer taken at the rising edge that sees pready high
      while (rdy !== 1'b1 && n < 50) begin
         @(posedge pclk);
         rdy = pready;
         n++;
      end
      r = prdata;
      e = pslverr;
      if (rdy !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd & m, e);
   endtask
   task automatic settle();
      repeat (12) @(posedge pclk);
   endtask
   task automatic pb(input logic [7:0] b, input logic e);
      i2cs_bfm_inst.put_byte(b, ack);
      settle();
      chk(32'(ack), 32'(e));
   endtask
   task automatic oe(input logic e);
      settle();
      chk(32'(scl_oe), 32'(e));
   endtask

   // Hang guard
   initial begin
      #500000;
      n_mismatch++;
      close_out();
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      void'($urandom(26647));
      adr = 10'($urandom());
      d0  = 8'($urandom());
      d1  = 8'($urandom());
      d2  = 8'($urandom());
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then an unmapped offset
      rchk(OFS_CTRL, 32'hFFFF, M_REL);
      rchk(OFS_STAT, 32'hFFFF, 32'h0);
      rchk(OFS_ADDR, 32'hFFFF, 32'h0);
      apb(1'b0, 8'h40, 32'h0, rd, er);
      chk(32'(er), 32'h1);
      wr(OFS_ADDR, {22'h0, adr});
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b0));
      rchk(OFS_CTRL, M_REL, M_REL);
      // Disabled module ignores its own address
      wr(OFS_CTRL, M_REL);
      i2cs_bfm_inst.start();
      pb({adr[6:0], 1'b0}, 1'b0);
      i2cs_bfm_inst.stop();
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b1));
      // Seven-bit write: fresh byte, full buffer, stale overflow
      i2cs_bfm_inst.start();
      pb({adr[6:0], 1'b0}, 1'b1);
      chk(n_evt, 1);
      rchk(OFS_STAT, M_RBF, 32'h0);
      pb(d0, rx_ack(1'b0, 1'b0));
      pb(d1, rx_ack(1'b1, 1'b0));
      chk(n_evt, 3);
      rchk(OFS_STAT, M_RBF | M_OV, M_RBF | M_OV);
      rchk(OFS_RXB, 32'hFF, 32'(d0));
      pb(d2, rx_ack(1'b0, 1'b1));
      rchk(OFS_RXB, 32'hFF, 32'(d2));
      i2cs_bfm_inst.stop();
      wr(OFS_STAT, 32'h8);
      // Foreign address draws no answer and no event
      i2cs_bfm_inst.start();
      pb({adr[6:0] ^ 7'h01, 1'b0}, 1'b0);
      chk(n_evt, 4);
      i2cs_bfm_inst.stop();
      // Seven-bit read: stretch for data, then a preloaded byte
      i2cs_bfm_inst.start();
      pb({adr[6:0], 1'b1}, 1'b1);
      chk(32'(scl_oe), 32'h1);
      rchk(OFS_CTRL, M_REL, 32'h0);
      wr(OFS_TXB, 32'(d0));
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b1));
      oe(1'b0);
      wr(OFS_TXB, 32'(d1));
      i2cs_bfm_inst.get_byte(1'b1, got);
      chk(32'(got), 32'(d0));
      oe(1'b0);
      rchk(OFS_CTRL, M_REL, M_REL);
      i2cs_bfm_inst.get_byte(1'b0, got);
      chk(32'(got), 32'(d1));
      settle();
      chk(n_evt, 7);
      i2cs_bfm_inst.stop();
      // Software hold waits for a fall; receive stretch on full buffer
      // Stretch enable must already be on for a release clear to count
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b1));
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b0));
      rchk(OFS_CTRL, M_REL, 32'h0);
      oe(1'b0);
      i2cs_bfm_inst.start();
      oe(1'b1);
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b1));
      i2cs_bfm_inst.put_byte({adr[6:0], 1'b0}, ack);
      pb(d1, 1'b1);
      chk(32'(scl_oe), 32'h1);
      rchk(OFS_CTRL, M_REL, 32'h0);
      rchk(OFS_RXB, 32'hFF, 32'(d1));
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b1));
      oe(1'b0);
      i2cs_bfm_inst.stop();
      // Ten-bit write, restart into read, then a wrong low byte
      wr(OFS_CTRL, ctl(1'b0, 1'b1, 1'b1));
      i2cs_bfm_inst.start();
      pb(hdr10(adr, 1'b0), 1'b1);
      rchk(OFS_STAT, M_TEN, 32'h0);
      pb(adr[7:0], 1'b1);
      rchk(OFS_STAT, M_TEN, M_TEN);
      chk(n_evt, 11);
      i2cs_bfm_inst.start();
      pb(hdr10(adr, 1'b1), 1'b1);
      oe(1'b1);
      wr(OFS_TXB, 32'(d2));
      wr(OFS_CTRL, ctl(1'b0, 1'b1, 1'b1));
      i2cs_bfm_inst.get_byte(1'b0, got);
      chk(32'(got), 32'(d2));
      i2cs_bfm_inst.stop();
      i2cs_bfm_inst.start();
      pb(hdr10(adr, 1'b0), 1'b1);
      pb(adr[7:0] ^ 8'h80, 1'b0);
      rchk(OFS_STAT, M_TEN, 32'h0);
      i2cs_bfm_inst.stop();
      close_out();
   end
endmodule
